//--- logic/clock_mode_regs.vh
`ifndef CLOCK_MODE_REGS_VH
`define CLOCK_MODE_REGS_VH
// register byte offsets
`define OFS_CTRL1 12'h000
`define OFS_CTRL2 12'h004
`define OFS_PLLCFG 12'h008
`define OFS_STATUS 12'h00C
`define OFS_SYSDIV 12'h010
`define OFS_RTCSEL 12'h014
`define OFS_RTCOSC 12'h018
`define OFS_COMPUTE 12'h01C
`define OFS_ACCESS 12'h020
// ctrl1 fields
`define C1_SRC_HI 7
`define C1_SRC_LO 6
`define C1_FDIV_HI 5
`define C1_FDIV_LO 3
`define C1_IREF 2
// ctrl2 fields
`define C2_RANGE_HI 5
`define C2_RANGE_LO 4
`define C2_HGAIN 3
`define C2_EXTKIND 2
// pllcfg fields
`define PC_MON_EN 7
`define PC_MON_RST 6
`define PC_PLLSEL 5
`define PC_MULT_HI 4
`define PC_MULT_LO 0
`define PC_PDIV_HI 12
`define PC_PDIV_LO 8
// status fields
`define ST_LOCK 6
`define ST_PLL_SELECTED_STATUS 5
`define ST_INTERNAL_REFERENCE_STATUS 4
`define ST_SRC_HI 3
`define ST_SRC_LO 2
`define ST_OSCRDY 1
`define ST_MONFLT 0
// output source codes
`define SRC_PLL 2'h0
`define SRC_INT 2'h1
`define SRC_EXT 2'h2
`define SST_FLL 2'h0
`define SST_INT 2'h1
`define SST_EXT 2'h2
`define SST_PLL 2'h3
// rtc source codes
`define RTC_OSC 2'h0
`define RTC_PIN 2'h2
`define RTC_LPO 2'h3
// reset values
`define RST_CTRL1 8'h04
`define RST_CTRL2 8'h00
`define RST_SYSDIV 8'h00
// timing
`define OSC_START_CYC 16'h0400
`define LOCK_CYC 16'h0800
`define SWITCH_CYC 4'h3
`define MON_LIMIT 8'hFF
`endif

//--- logic/sync_2ff.v
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
    parameter WIDTH = 1
) (
    input wire clk_i, // clock
    input wire rst_n_i, // reset, active low
    input wire [WIDTH-1:0] d_i, // async input
    output wire [WIDTH-1:0] q_o // synced output
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;
    // two stages, first read only by second
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end
    assign q_o = sync_ff;
endmodule
`default_nettype wire

//--- logic/ready_timer.v
`timescale 1ns/1ps
`default_nettype none
module ready_timer #(
    parameter WIDTH = 16
) (
    input wire clk_i, // clock
    input wire rst_n_i, // reset, active low
    input wire run_i, // count while high, clear when low
    input wire [WIDTH-1:0] limit_i, // cycles until done
    output reg done_o // high once limit reached
);
    reg [WIDTH-1:0] cnt_ff;
    // counts up while run; done sticks until run drops
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_ff <= {WIDTH{1'b0}};
            done_o <= 1'b0;
        end else if (!run_i) begin
            cnt_ff <= {WIDTH{1'b0}};
            done_o <= 1'b0;
        end else if (cnt_ff >= limit_i) begin
            done_o <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

//--- logic/clock_mode_generator_control.v
// How it works
// - any reset comes up in fll_internal_engaged_mode, internal reference selected.
// - pll output clock divider is fixed at half the pll frequency.
// - source code 10 selects external; clearing internal select enables oscillator.
// - oscillator ready flag sets after oscillator startup time.
// - status field reports real source; internal status clears on external use.
// - clock monitor fault raises interrupt or reset, as configured.
// - pll select with external source enables pll, output unchanged.
// - pll selected status and separate lock flag are reported.
// - pll divider code 1 divides by 2; multiplier code 0 gives 96 MHz.
// - fll divider ratio depends on range; code 3 at 8 MHz gives 256.
// - clearing source field with pll locked switches output to pll.
// - rtc source: 0 oscillator, 2 input pin, 3 low power oscillator.
// - oscillator 32k only with 32k range and high gain off, not deepest stop.
// - in deepest stop only the input pin clocks the rtc.
// - rtc timekeeping flagged valid only for a 32.768 kHz source.
// - rtc oscillator registers reset only at power on.
// - compute request set or cleared is followed by matching acknowledge.
// - during compute, off-platform access errors, gpio inputs unreadable.
// - dma request leaves compute and resumes it after the transfer.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "clock_mode_regs.vh"
module clock_mode_generator_control #(
    parameter PLL_DIV_W = 5,
    parameter OSC_START = `OSC_START_CYC,
    parameter LOCK_TIME = `LOCK_CYC
) (
    input wire ref_clk_i, // 25 MHz clock
    input wire resetn_i, // any reset, active low
    input wire por_n_i, // power-on reset, active low
    input wire psel_i, // apb select
    input wire penable_i, // apb enable
    input wire pwrite_i, // apb write
    input wire [11:0] paddr_i, // apb byte address
    input wire [31:0] pwdata_i, // apb write data
    output reg [31:0] prdata_o, // apb read data
    output reg pready_o, // apb ready
    output reg pslverr_o, // apb error
    input wire osc_clock_alive_i, // external oscillator toggling, async
    input wire rtc_pin_is_32k_i, // pin source at 32.768 kHz, async
    input wire deepest_stop_i, // deepest leakage stop active, async
    input wire dma_req_i, // dma request pending
    input wire dma_done_i, // dma transfer complete pulse
    input wire periph_req_i, // peripheral bus access request
    input wire periph_gpio_in_i, // access is a gpio input read
    output reg [1:0] out_src_sel_o, // 0 fll 1 int 2 ext 3 pll
    output reg osc_enable_o, // external oscillator enable
    output reg pll_enable_o, // pll enable
    output reg [4:0] pll_ref_div_o, // pll reference divide minus one
    output reg [4:0] pll_mult_o, // pll multiplier code
    output reg [10:0] fll_div_o, // fll reference divide ratio
    output reg [1:0] pll_post_div_o, // pll to system divide ratio
    output reg [3:0] core_div_o, // core divider code
    output reg [3:0] bus_div_o, // bus divider code
    output reg [1:0] rtc_src_o, // rtc 32k source mux
    output reg rtc_clock_valid_o, // rtc source is usable
    output reg rtc_time_valid_o, // timekeeping accurate
    output reg mon_irq_o, // clock monitor interrupt
    output reg mon_reset_o, // clock monitor reset request
    output reg periph_gate_o, // peripheral clocks gated
    output reg periph_err_o // bus error to peripheral access
);
    wire rst_n;
    reg rst_meta_ff, rst_sync_ff;
    // reset release through two stages
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rst_n = rst_sync_ff;
    wire osc_alive, pin32k, deep_stop;
    sync_2ff #(.WIDTH(3)) u_sync (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .d_i({osc_clock_alive_i, rtc_pin_is_32k_i, deepest_stop_i}),
        .q_o({osc_alive, pin32k, deep_stop})
    );
    // control registers, reset by any reset
    reg [7:0] ctrl1_ff, ctrl2_ff, sysdiv_ff;
    reg [7:0] pllcfg_lo_ff;
    reg [PLL_DIV_W-1:0] pdiv_ff;
    reg [1:0] rtcsel_ff;
    reg cpo_req_ff, cpo_ack_ff, dma_exit_ff;
    // rtc oscillator register survives all but power on
    reg [4:0] rtcosc_ff;
    reg [1:0] cur_src_ff;
    reg [3:0] sw_cnt_ff;
    reg mon_flt_ff;
    reg [7:0] mon_cnt_ff;
    wire osc_ready, pll_locked;
    wire wr_en = psel_i && penable_i && pwrite_i && pready_o;
    wire apb_setup = psel_i && !penable_i;
    wire [1:0] src_req = ctrl1_ff[`C1_SRC_HI:`C1_SRC_LO];
    wire pll_sel = pllcfg_lo_ff[`PC_PLLSEL];
    // fll ratio from range and divider code
    function [10:0] fll_ratio;
        input [1:0] range;
        input [2:0] code;
        begin
            if (range == 2'h0)
                fll_ratio = 11'h001 << code;
            else if (code > 3'h5)
                fll_ratio = 11'h400 >> (3'h7 - code);
            else
                fll_ratio = 11'h020 << code;
        end
    endfunction
    // register word match, shared by the write and clear paths
    function wr_hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            wr_hit = (addr == ofs);
        end
    endfunction
    ready_timer #(.WIDTH(16)) u_osc_tmr (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .run_i(osc_enable_o && osc_alive),
        .limit_i(OSC_START),
        .done_o(osc_ready)
    );
    // lock after lock time with pll on
    ready_timer #(.WIDTH(16)) u_lock_tmr (
        .clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .run_i(pll_enable_o && osc_ready),
        .limit_i(LOCK_TIME),
        .done_o(pll_locked)
    );
    // register writes
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl1_ff <= `RST_CTRL1;
            ctrl2_ff <= `RST_CTRL2;
            sysdiv_ff <= `RST_SYSDIV;
            pllcfg_lo_ff <= 8'h00;
            pdiv_ff <= {PLL_DIV_W{1'b0}};
            rtcsel_ff <= `RTC_OSC;
            cpo_req_ff <= 1'b0;
        end else if (wr_en) begin
            case (paddr_i)
                `OFS_CTRL1: ctrl1_ff <= pwdata_i[7:0];
                `OFS_CTRL2: ctrl2_ff <= pwdata_i[7:0];
                `OFS_PLLCFG: begin
                    pllcfg_lo_ff <= pwdata_i[7:0];
                    pdiv_ff <= pwdata_i[`PC_PDIV_LO+PLL_DIV_W-1:`PC_PDIV_LO];
                end
                `OFS_SYSDIV: sysdiv_ff <= pwdata_i[7:0];
                `OFS_RTCSEL: rtcsel_ff <= pwdata_i[1:0];
                `OFS_COMPUTE: cpo_req_ff <= pwdata_i[0];
                default: ;
            endcase
        end
    end
    always @(posedge ref_clk_i or negedge por_n_i) begin
        if (!por_n_i)
            rtcosc_ff <= 5'h00;
        else if (wr_en && wr_hit(paddr_i, `OFS_RTCOSC))
            rtcosc_ff <= pwdata_i[4:0];
    end
    // switch only after quiet wait, source must be ready
    wire [1:0] want_src = (src_req == `SRC_EXT) ? `SST_EXT :
                          (src_req == `SRC_INT) ? `SST_INT :
                          (pll_sel ? `SST_PLL : `SST_FLL);
    wire want_ok = (want_src == `SST_EXT) ? osc_ready :
                   (want_src == `SST_PLL) ? pll_locked : 1'b1;
    // limitation: a source that fails after the switch keeps the output on it;
    // the clock monitor is what reports that case
    reg [1:0] want_last_ff;
    // a target that moves mid-wait restarts the quiet count, so the mux never
    // lands on a target that was not stable for the whole wait
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n)
            want_last_ff <= `SST_FLL;
        else
            want_last_ff <= want_src;
    end
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cur_src_ff <= `SST_FLL;
            sw_cnt_ff <= 4'h0;
        end else if (want_src == cur_src_ff || !want_ok || want_src != want_last_ff) begin
            sw_cnt_ff <= 4'h0;
        end else if (sw_cnt_ff >= `SWITCH_CYC) begin
            cur_src_ff <= want_src;
            sw_cnt_ff <= 4'h0;
        end else begin
            sw_cnt_ff <= sw_cnt_ff + 4'h1;
        end
    end
    // monitor: oscillator lost while in use
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mon_cnt_ff <= 8'h00;
            mon_flt_ff <= 1'b0;
        end else begin
            if (!pllcfg_lo_ff[`PC_MON_EN] || osc_alive || !osc_enable_o)
                mon_cnt_ff <= 8'h00;
            else if (mon_cnt_ff != `MON_LIMIT)
                mon_cnt_ff <= mon_cnt_ff + 8'h01;
            // set wins over clear
            if (mon_cnt_ff == `MON_LIMIT)
                mon_flt_ff <= 1'b1;
            else if (wr_en && wr_hit(paddr_i, `OFS_STATUS) && pwdata_i[`ST_MONFLT])
                mon_flt_ff <= 1'b0;
        end
    end
    // acknowledge follows request; dma leaves compute
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cpo_ack_ff <= 1'b0;
            dma_exit_ff <= 1'b0;
        end else begin
            if (dma_req_i)
                dma_exit_ff <= 1'b1;
            else if (dma_done_i)
                dma_exit_ff <= 1'b0;
            cpo_ack_ff <= cpo_req_ff;
        end
    end
    wire cpo_active = cpo_ack_ff && !dma_exit_ff;
    wire osc32k_ok = rtcosc_ff[0] && ctrl2_ff[`C2_RANGE_HI:`C2_RANGE_LO] == 2'h0 &&
                     !ctrl2_ff[`C2_HGAIN] && !deep_stop;
    reg rtc_ok, rtc_acc;
    // rtc source availability
    always @* begin
        rtc_ok = 1'b0;
        rtc_acc = 1'b0;
        case (rtcsel_ff)
            `RTC_OSC: begin
                rtc_ok = osc32k_ok;
                rtc_acc = osc32k_ok;
            end
            // pin is the only source in deepest stop
            `RTC_PIN: begin
                rtc_ok = 1'b1;
                rtc_acc = pin32k;
            end
            `RTC_LPO: begin
                rtc_ok = !deep_stop;
                rtc_acc = 1'b0;
            end
            default: ;
        endcase
    end
    // status reports the source that really drives the output
    wire pll_sel_st = pll_enable_o & osc_ready;
    // internal status holds until the oscillator can take over the fll reference
    wire iref_st = ctrl1_ff[`C1_IREF] ? (cur_src_ff == `SST_FLL || cur_src_ff == `SST_INT) : !osc_ready;
    wire [31:0] status_w = {25'h0, pll_locked, pll_sel_st, iref_st, cur_src_ff, osc_ready, mon_flt_ff};
    // outputs from flip-flops
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            out_src_sel_o <= `SST_FLL;
            osc_enable_o <= 1'b0;
            pll_enable_o <= 1'b0;
            pll_ref_div_o <= 5'h00;
            pll_mult_o <= 5'h00;
            fll_div_o <= 11'h001;
            pll_post_div_o <= 2'h2;
            core_div_o <= 4'h0;
            bus_div_o <= 4'h0;
            rtc_src_o <= `RTC_OSC;
            rtc_clock_valid_o <= 1'b0;
            rtc_time_valid_o <= 1'b0;
            mon_irq_o <= 1'b0;
            mon_reset_o <= 1'b0;
            periph_gate_o <= 1'b0;
            periph_err_o <= 1'b0;
        end else begin
            out_src_sel_o <= cur_src_ff;
            osc_enable_o <= !ctrl1_ff[`C1_IREF];
            // pll runs while output stays external
            pll_enable_o <= pll_sel && !ctrl1_ff[`C1_IREF];
            // stored code is divide minus one
            pll_ref_div_o <= pdiv_ff[4:0];
            pll_mult_o <= pllcfg_lo_ff[`PC_MULT_HI:`PC_MULT_LO];
            fll_div_o <= fll_ratio(ctrl2_ff[`C2_RANGE_HI:`C2_RANGE_LO],
                                   ctrl1_ff[`C1_FDIV_HI:`C1_FDIV_LO]);
            pll_post_div_o <= 2'h2;
            core_div_o <= sysdiv_ff[7:4];
            bus_div_o <= sysdiv_ff[3:0];
            rtc_src_o <= rtcsel_ff;
            rtc_clock_valid_o <= rtc_ok;
            // timekeeping valid only at 32.768 kHz
            rtc_time_valid_o <= rtc_ok && rtc_acc;
            mon_irq_o <= mon_flt_ff && !pllcfg_lo_ff[`PC_MON_RST];
            mon_reset_o <= mon_flt_ff && pllcfg_lo_ff[`PC_MON_RST];
            periph_gate_o <= cpo_active;
            // off-platform access errors in compute
            // every access on this port counts as off-platform; platform paths never reach it
            periph_err_o <= cpo_active && periph_req_i;
        end
    end
    // apb slave: no wait states, error on unmapped
    always @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
        end else begin
            pready_o <= apb_setup;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
            if (apb_setup) begin
                case (paddr_i)
                    `OFS_CTRL1: prdata_o <= {24'h0, ctrl1_ff};
                    `OFS_CTRL2: prdata_o <= {24'h0, ctrl2_ff};
                    `OFS_PLLCFG: prdata_o <= {19'h0, pdiv_ff[4:0], pllcfg_lo_ff};
                    `OFS_STATUS: prdata_o <= status_w;
                    `OFS_SYSDIV: prdata_o <= {24'h0, sysdiv_ff};
                    `OFS_RTCSEL: prdata_o <= {30'h0, rtcsel_ff};
                    `OFS_RTCOSC: prdata_o <= {27'h0, rtcosc_ff};
                    `OFS_COMPUTE: prdata_o <= {30'h0, cpo_ack_ff, cpo_req_ff};
                    `OFS_ACCESS: prdata_o <= {30'h0, cpo_active & periph_gpio_in_i, cpo_active};
                    default: pslverr_o <= 1'b1;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/clock_mode_sva.sv
`timescale 1ns/1ps
`default_nettype none
module clock_mode_sva (
    input wire logic ref_clk_i, // clock
    input wire logic resetn_i, // reset, active low
    input wire logic psel_i, // apb select
    input wire logic penable_i, // apb enable
    input wire logic pready_o, // apb ready
    input wire logic pslverr_o, // apb error
    input wire logic periph_req_i, // peripheral access
    input wire logic periph_err_o, // peripheral error
    input wire logic [1:0] out_src_sel_o, // output source
    input wire logic osc_enable_o, // oscillator enable
    input wire logic pll_enable_o, // pll enable
    input wire logic [1:0] pll_post_div_o, // pll post divide
    input wire logic deepest_stop_i, // deepest stop
    input wire logic [1:0] rtc_src_o, // rtc source
    input wire logic rtc_clock_valid_o, // rtc clock usable
    input wire logic mon_irq_o, // monitor interrupt
    input wire logic mon_reset_o // monitor reset
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    a_reset_mode: assert property ($rose(resetn_i) |-> out_src_sel_o == 2'h0)
        else $error("not fll internal after reset");
    a_post_half: assert property (pll_post_div_o == 2'h2)
        else $error("pll post divide not two");
    a_ext_osc: assert property (out_src_sel_o == 2'h2 |-> osc_enable_o)
        else $error("external source without oscillator");
    a_pll_keeps_src: assert property ($rose(pll_enable_o) |-> $stable(out_src_sel_o))
        else $error("source moved when pll enabled");
    a_pll_switch: assert property ($changed(out_src_sel_o) && out_src_sel_o == 2'h3 |->
        pll_enable_o && $past(pll_enable_o, 4)) else $error("switch to pll not locked");
    a_mon_either: assert property (!(mon_irq_o && mon_reset_o))
        else $error("monitor raised both actions");
    // apb answer is a single-cycle pulse after setup
    a_ready_pulse: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
        else $error("ready not one cycle after setup");
    a_slverr_ready: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    a_err_cause: assert property (periph_err_o |-> $past(periph_req_i))
        else $error("bus error without access");
    a_deep_pin: assert property ((deepest_stop_i && rtc_src_o != 2'h2)[*5] |-> !rtc_clock_valid_o)
        else $error("rtc clock valid in deepest stop");
endmodule
bind clock_mode_generator_control clock_mode_sva clock_mode_sva_inst (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .periph_req_i(periph_req_i), .periph_err_o(periph_err_o),
    .out_src_sel_o(out_src_sel_o), .osc_enable_o(osc_enable_o), .pll_enable_o(pll_enable_o),
    .pll_post_div_o(pll_post_div_o), .deepest_stop_i(deepest_stop_i), .rtc_src_o(rtc_src_o),
    .rtc_clock_valid_o(rtc_clock_valid_o), .mon_irq_o(mon_irq_o), .mon_reset_o(mon_reset_o));
`default_nettype wire

//--- testbench/osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module osc_model #(
    parameter int START_CYC = 4
) (
    input wire logic clk_i, // clock
    input wire logic enable_i, // oscillator enable
    input wire logic broken_i, // commanded fault
    output logic alive_o // oscillator running
);
    int cnt = 0;
    // startup delay; a broken crystal never starts, so the monitor has work
    always @(posedge clk_i) begin
        cnt <= (enable_i && !broken_i) ? cnt + 1 : 0;
        alive_o <= enable_i && !broken_i && cnt >= START_CYC;
    end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "clock_mode_regs.vh"
module tb_top;
    typedef struct packed {logic [11:0] a; logic [31:0] d; logic e;} row_t;
    logic ref_clk_i = 1'b0, resetn_i = 1'b0, por_n_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic rtc_pin_is_32k_i = 1'b1, deepest_stop_i = 1'b0, dma_req_i = 1'b0, dma_done_i = 1'b0;
    logic periph_req_i = 1'b0, periph_gpio_in_i = 1'b0, osc_broken = 1'b0;
    wire logic osc_clock_alive_i, pready_o, pslverr_o, osc_enable_o, pll_enable_o, rtc_clock_valid_o;
    wire logic rtc_time_valid_o, mon_irq_o, mon_reset_o, periph_gate_o, periph_err_o;
    wire logic [31:0] prdata_o;
    wire logic [1:0] out_src_sel_o, pll_post_div_o, rtc_src_o;
    wire logic [4:0] pll_ref_div_o, pll_mult_o;
    wire logic [10:0] fll_div_o;
    wire logic [3:0] core_div_o, bus_div_o;
    logic [31:0] rd;
    logic er;
    integer err_total = 0, checks_done = 0, cyc = 0, i;
    // reset-time register image; last row is an unmapped word
    row_t rows [7] = '{'{`OFS_CTRL1, 32'h4, 1'b0}, '{`OFS_CTRL2, 32'h0, 1'b0}, '{`OFS_PLLCFG, 32'h0, 1'b0},
        '{`OFS_STATUS, 32'h10, 1'b0}, '{`OFS_SYSDIV, 32'h0, 1'b0}, '{`OFS_COMPUTE, 32'h0, 1'b0},
        '{12'h024, 32'h0, 1'b1}};
    logic [1:0] rtc_code [3] = '{2'h0, 2'h2, 2'h3};
    logic [1:0] rtc_ok [3] = '{2'h0, 2'h3, 2'h2};

    clock_mode_generator_control #(.OSC_START(16'h0008), .LOCK_TIME(16'h0008)) clock_mode_generator_control_inst (
        .ref_clk_i, .resetn_i, .por_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .osc_clock_alive_i, .rtc_pin_is_32k_i, .deepest_stop_i, .dma_req_i,
        .dma_done_i, .periph_req_i, .periph_gpio_in_i, .out_src_sel_o, .osc_enable_o, .pll_enable_o,
        .pll_ref_div_o, .pll_mult_o, .fll_div_o, .pll_post_div_o, .core_div_o, .bus_div_o, .rtc_src_o,
        .rtc_clock_valid_o, .rtc_time_valid_o, .mon_irq_o, .mon_reset_o, .periph_gate_o, .periph_err_o);
    osc_model #(.START_CYC(4)) osc_model_inst (.clk_i(ref_clk_i), .enable_i(osc_enable_o),
        .broken_i(osc_broken), .alive_o(osc_clock_alive_i));

    // 25 MHz
    initial forever #20 ref_clk_i = ~ref_clk_i;

    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // apb master: hold request until pready is seen at an edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        paddr_i <= a;
        pwrite_i <= w;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        @(posedge ref_clk_i);
        while (pready_o !== 1'b1) @(posedge ref_clk_i);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    // bounded register poll, never an endless loop
    task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        integer n;
        n = 0;
        do begin
            apb(a, 1'b0, 32'h0);
            n = n + 1;
        end while ((rd & m) !== v && n < 100);
        chk(rd & m, v);
    endtask

    // hang guard
    always @(posedge ref_clk_i) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            err_total = err_total + 1;
            complete_run;
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        por_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        for (i = 0; i < 7; i = i + 1) begin
            apb(rows[i].a, 1'b0, 32'h0);
            chk(er, rows[i].e);
            if (!rows[i].e) chk(rd, rows[i].d);
        end
        chk(fll_div_o, 32'h1);
        // step to external bypass, checking each entry
        apb(`OFS_CTRL2, 1'b1, 32'h14);
        apb(`OFS_CTRL1, 1'b1, 32'h98);
        rchk(`OFS_STATUS, 32'h2, 32'h2);
        rchk(`OFS_STATUS, 32'h1C, 32'h08);
        chk(out_src_sel_o, 32'h2);
        chk(osc_enable_o, 32'h1);
        chk(fll_div_o, 32'h100);
        // pll on while still on external reference
        apb(`OFS_PLLCFG, 1'b1, 32'h1A0);
        // registered outputs follow one edge after the write lands
        @(posedge ref_clk_i);
        chk(out_src_sel_o, 32'h2);
        chk(pll_enable_o, 32'h1);
        chk({pll_ref_div_o, pll_mult_o}, 32'h20);
        rchk(`OFS_STATUS, 32'h60, 32'h60);
        apb(`OFS_SYSDIV, 1'b1, 32'h11);
        @(posedge ref_clk_i);
        chk({core_div_o, bus_div_o}, 32'h11);
        apb(`OFS_CTRL1, 1'b1, 32'h18);
        rchk(`OFS_STATUS, 32'h0C, 32'h0C);
        chk(out_src_sel_o, 32'h3);
        // rtc sources; oscillator is in fast range so its 32k clock is absent
        for (i = 0; i < 3; i = i + 1) begin
            apb(`OFS_RTCSEL, 1'b1, {30'h0, rtc_code[i]});
            repeat (4) @(posedge ref_clk_i);
            chk(rtc_src_o, rtc_code[i]);
            chk({rtc_clock_valid_o, rtc_time_valid_o}, rtc_ok[i]);
        end
        deepest_stop_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        chk(rtc_clock_valid_o, 32'h0);
        apb(`OFS_RTCSEL, 1'b1, 32'h2);
        repeat (6) @(posedge ref_clk_i);
        chk(rtc_clock_valid_o, 32'h1);
        deepest_stop_i <= 1'b0;
        // compute-only entry, blocked access, dma excursion, exit
        apb(`OFS_COMPUTE, 1'b1, 32'h1);
        rchk(`OFS_COMPUTE, 32'h2, 32'h2);
        periph_req_i <= 1'b1;
        periph_gpio_in_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk(periph_err_o, 32'h1);
        chk(periph_gate_o, 32'h1);
        rchk(`OFS_ACCESS, 32'h3, 32'h3);
        dma_req_i <= 1'b1;
        rchk(`OFS_ACCESS, 32'h1, 32'h0);
        chk(periph_gate_o, 32'h0);
        dma_req_i <= 1'b0;
        dma_done_i <= 1'b1;
        @(posedge ref_clk_i);
        dma_done_i <= 1'b0;
        rchk(`OFS_ACCESS, 32'h1, 32'h1);
        periph_req_i <= 1'b0;
        apb(`OFS_COMPUTE, 1'b1, 32'h0);
        rchk(`OFS_COMPUTE, 32'h2, 32'h0);
        // dead crystal with monitor in interrupt mode
        osc_broken <= 1'b1;
        repeat (300) @(posedge ref_clk_i);
        chk({mon_irq_o, mon_reset_o}, 32'h2);
        rchk(`OFS_STATUS, 32'h1, 32'h1);
        // ordinary reset keeps rtc oscillator settings, power-on clears them
        apb(`OFS_RTCOSC, 1'b1, 32'h1F);
        resetn_i <= 1'b0;
        osc_broken <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        rchk(`OFS_RTCOSC, 32'hFFFFFFFF, 32'h1F);
        rchk(`OFS_CTRL1, 32'hFFFFFFFF, 32'h4);
        chk(out_src_sel_o, 32'h0);
        por_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        por_n_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rchk(`OFS_RTCOSC, 32'hFFFFFFFF, 32'h0);
        // monitor in reset mode
        apb(`OFS_CTRL2, 1'b1, 32'h14);
        apb(`OFS_CTRL1, 1'b1, 32'h98);
        rchk(`OFS_STATUS, 32'h2, 32'h2);
        apb(`OFS_PLLCFG, 1'b1, 32'hC0);
        osc_broken <= 1'b1;
        repeat (300) @(posedge ref_clk_i);
        chk({mon_irq_o, mon_reset_o}, 32'h1);
        complete_run;
    end
endmodule
`default_nettype wire
